// File: hw/usart_core.sv
// Serial unit core: clocks, transmit buffer, receive FIFO
//
// Overview of operation
// - One transmit buffer allows back-to-back frames
// - Two-entry receive FIFO, each read pops one
// - Error flags and ninth bit stored per entry
// - Full FIFO: shift register holds third character
// - Receiver detects frame, overrun and parity errors
// - Five to nine data bits, parity, stops
// - Sync select; clock direction picks master/slave
// - Transfer clock pin used only in sync
// - External transfer clock synchronised before use
// - Divisor counter reloads at zero, low write
// - One tick per zero: clk/(divisor+1)
// - Divisor is twelve bits, 0 to 4095
// - Transmit clock: tick over 16, 8, 2
// - Receiver recovery uses 16 or 8 states
// - Clock/data recovery for asynchronous reception
// - Double speed affects asynchronous mode only
// - Double speed: eight samples per bit
// - Transmit complete, buffer empty, receive complete
// - Low-pass filter and false start rejection
// - External clock edge detect costs two cycles
// - Polarity picks change and sample edges
// - Start bit, LSB first, parity, stop, idle high
`timescale 1ns/1ns
module usart_core import usart_pkg::*; #(
   parameter int RX_DEPTH = RX_FIFO_DEPTH_DEF
) (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       serial_power_reduce_bit_i,
   input  wire logic       tx_enable_i,
   input  wire logic       rx_enable_i,
   input  wire logic       sync_mode_select_i,
   input  wire logic       double_speed_bit_i,
   input  wire logic       transfer_clock_direction_i,
   input  wire logic       sync_clock_polarity_i,
   input  wire logic [2:0] char_size_i,
   input  wire logic [1:0] parity_mode_i,
   input  wire logic       two_stop_i,
   input  wire logic [7:0] baud_divisor_low_i,
   input  wire logic [3:0] baud_divisor_high_i,
   input  wire logic       baud_divisor_low_wr_i,
   input  wire logic [8:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   output logic            tx_empty_o,
   output logic            tx_complete_o,
   input  wire logic       tx_complete_clr_i,
   output logic [7:0]      serial_data_location_o,
   output logic            rx_ninth_bit_o,
   output logic            frame_error_flag_o,
   output logic            overrun_flag_o,
   output logic            parity_error_o,
   output logic            rx_complete_o,
   input  wire logic       rx_pop_i,
   output logic            txd_o,
   output logic            txd_oe_o,
   input  wire logic       rxd_i,
   input  wire logic       transfer_clock_pin_i,
   output logic            transfer_clock_pin_o,
   output logic            transfer_clock_pin_oe_o
);

   logic                 run;
   logic                 sync_m;
   logic                 master_m;
   logic                 slave_m;
   logic                 baud_tick;
   logic [4:0]           spb;
   logic [3:0]           spb_m1;
   logic [3:0]           half_m1;
   logic [3:0]           nbits;
   logic                 par_en;
   logic                 par_odd;
   logic                 xck_ff;
   logic                 xs1_ff;
   logic                 xs2_ff;
   logic                 xs3_ff;
   logic                 clk_rise;
   logic                 clk_fall;
   logic                 chg_edge;
   logic                 smp_edge;
   tx_state_t            tx_state_ff;
   logic [8:0]           txb_ff;
   logic                 txb_full_ff;
   logic [FRAME_W-1:0]   tx_sh_ff;
   logic [3:0]           tx_left_ff;
   logic [3:0]           tx_pre_ff;
   logic                 tx_done_ff;
   logic [FRAME_W-1:0]   frame_w;
   logic [3:0]           frame_len;
   logic                 tx_tick;
   logic                 tx_last;
   logic                 tx_load;
   logic                 tx_run;
   rx_state_t            rx_state_ff;
   logic [2:0]           rx_hist_ff;
   logic [3:0]           rx_cnt_ff;
   logic [3:0]           rx_idx_ff;
   logic [8:0]           rx_sh_ff;
   logic                 rx_par_ff;
   logic                 rx_fe_ff;
   logic                 rx_pe_ff;
   logic                 ovr_pend_ff;
   logic                 rx_maj;
   logic                 rx_bit;
   logic                 rx_tick;
   logic                 start_seen;
   logic                 rx_run;
   logic                 fifo_in_ready;
   logic                 rx_push;
   logic [8:0]           rx_aligned;
   logic [RX_WORD_W-1:0] rx_head;

   // Send order, bit 0 first; unused top bits stay high
   function automatic logic [FRAME_W-1:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                                      input logic pen, input logic odd);
      logic p;
      p = odd;
      build_frame = '1;
      build_frame[0] = 1'b0;
      for (int i = 0; i < DATA_W; i++) begin
         if (i < int'(n)) begin
            build_frame[i+1] = d[i];
            p = p ^ d[i];
         end
      end
      for (int i = 1; i < FRAME_W; i++) begin
         if (pen && (i == int'(n) + 1)) build_frame[i] = p;
      end
   endfunction : build_frame

   // Mode and clock generation

   assign run      = !serial_power_reduce_bit_i;
   assign sync_m   = sync_mode_select_i;
   assign master_m = sync_m && transfer_clock_direction_i;
   assign slave_m  = sync_m && !transfer_clock_direction_i;
   assign nbits    = data_bits(char_size_i);
   assign par_en   = parity_mode_i[1];
   assign par_odd  = (parity_mode_i == PAR_ODD);

   // Double speed is ignored in sync mode
   assign spb     = (double_speed_bit_i && !sync_m) ? SPB_DOUBLE : SPB_NORMAL;
   assign spb_m1  = 4'(spb - 5'h01);
   assign half_m1 = 4'((spb >> 1) - 5'h01);

   usart_baud_gen #(
      .W (DIV_W)
   ) u_baud (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (run),
      .divisor_i ({baud_divisor_high_i, baud_divisor_low_i}),
      .reload_i  (baud_divisor_low_wr_i),
      .tick_o    (baud_tick)
   );

   // Master clock toggles each tick
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) xck_ff <= 1'b0;
      else if (!run || !master_m) xck_ff <= 1'b0;
      else if (baud_tick) xck_ff <= !xck_ff;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         xs1_ff <= 1'b0;
         xs2_ff <= 1'b0;
         xs3_ff <= 1'b0;
      end else begin
         xs1_ff <= transfer_clock_pin_i;
         xs2_ff <= xs1_ff;
         xs3_ff <= xs2_ff;
      end
   end

   // Sync plus edge detect delays the slave clock; keep it below clk/4
   assign clk_rise = master_m ? (baud_tick && !xck_ff)
                              : (slave_m && xs2_ff && !xs3_ff);
   assign clk_fall = master_m ? (baud_tick && xck_ff)
                              : (slave_m && !xs2_ff && xs3_ff);
   assign chg_edge = sync_clock_polarity_i ? clk_fall : clk_rise;
   assign smp_edge = sync_clock_polarity_i ? clk_rise : clk_fall;

   assign transfer_clock_pin_o    = xck_ff;
   assign transfer_clock_pin_oe_o = run && master_m;

   // Transmitter

   assign tx_run    = run && tx_enable_i;
   assign frame_w   = build_frame(txb_ff, nbits, par_en, par_odd);
   assign frame_len = 4'(4'h2 + nbits + {3'h0, par_en} + {3'h0, two_stop_i});
   assign tx_tick   = sync_m ? chg_edge : (baud_tick && (tx_pre_ff == spb_m1));
   assign tx_last   = (tx_state_ff == TX_SHIFT) && tx_tick && (tx_left_ff == 4'h1);
   // Next frame loads on the last stop bit's tick, so frames abut
   assign tx_load   = tx_run && txb_full_ff &&
                      ((tx_state_ff == TX_IDLE) ? (!sync_m || chg_edge) : tx_last);
   assign tx_ready_o = tx_run && !txb_full_ff;
   assign tx_empty_o = !txb_full_ff;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         txb_ff      <= '0;
         txb_full_ff <= 1'b0;
      end else if (!tx_run) begin
         txb_full_ff <= 1'b0;
      end else if (tx_valid_i && !txb_full_ff) begin
         txb_ff      <= tx_data_i;
         txb_full_ff <= 1'b1;
      end else if (tx_load) begin
         txb_full_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_state_ff <= TX_IDLE;
         tx_sh_ff    <= '1;
         tx_left_ff  <= '0;
         tx_pre_ff   <= '0;
      end else if (!tx_run) begin
         tx_state_ff <= TX_IDLE;
         tx_sh_ff    <= '1;
         tx_left_ff  <= '0;
         tx_pre_ff   <= '0;
      end else if (tx_load) begin
         tx_state_ff <= TX_SHIFT;
         tx_sh_ff    <= frame_w;
         tx_left_ff  <= frame_len;
         tx_pre_ff   <= '0;
      end else if (tx_state_ff == TX_SHIFT) begin
         if (baud_tick && !sync_m) begin
            tx_pre_ff <= (tx_pre_ff == spb_m1) ? 4'h0 : tx_pre_ff + 4'h1;
         end
         if (tx_tick) begin
            tx_sh_ff   <= {1'b1, tx_sh_ff[FRAME_W-1:1]};
            tx_left_ff <= tx_left_ff - 4'h1;
            if (tx_left_ff == 4'h1) tx_state_ff <= TX_IDLE;
         end
      end
   end

   // A completion in the same cycle as the clear wins
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) tx_done_ff <= 1'b0;
      else if (tx_last && !tx_load) tx_done_ff <= 1'b1;
      else if (tx_complete_clr_i) tx_done_ff <= 1'b0;
   end

   assign tx_complete_o = tx_done_ff;
   assign txd_o         = tx_sh_ff[0];
   assign txd_oe_o      = tx_run;

   // Receiver

   assign rx_run     = run && rx_enable_i;
   assign rx_maj     = (rx_hist_ff[0] & rx_hist_ff[1]) | (rx_hist_ff[1] & rx_hist_ff[2]) |
                       (rx_hist_ff[0] & rx_hist_ff[2]);
   assign rx_bit     = sync_m ? rxd_i : rx_maj;
   assign rx_tick    = sync_m ? smp_edge : (baud_tick && (rx_cnt_ff == half_m1));
   assign start_seen = sync_m ? (smp_edge && !rxd_i) : (baud_tick && !rx_maj);
   assign rx_push    = (rx_state_ff == RX_HOLD) && fifo_in_ready;
   assign rx_aligned = rx_sh_ff >> (4'h9 - nbits);

   // Three-tap majority is the low-pass filter
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) rx_hist_ff <= 3'h7;
      else if (!rx_run || sync_m) rx_hist_ff <= 3'h7;
      else if (baud_tick) rx_hist_ff <= {rx_hist_ff[1:0], rxd_i};
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_state_ff <= RX_IDLE;
         rx_cnt_ff   <= '0;
         rx_idx_ff   <= '0;
         rx_sh_ff    <= '0;
         rx_par_ff   <= 1'b0;
         rx_fe_ff    <= 1'b0;
         rx_pe_ff    <= 1'b0;
         ovr_pend_ff <= 1'b0;
      end else if (!rx_run) begin
         rx_state_ff <= RX_IDLE;
         ovr_pend_ff <= 1'b0;
      end else begin
         if (rx_push) ovr_pend_ff <= 1'b0;
         unique case (rx_state_ff)
            RX_IDLE: begin
               if (start_seen) begin
                  rx_state_ff <= RX_BUSY;
                  rx_cnt_ff   <= '0;
                  rx_idx_ff   <= sync_m ? 4'h1 : 4'h0;
                  rx_par_ff   <= 1'b0;
                  rx_pe_ff    <= 1'b0;
               end
            end
            RX_BUSY: begin
               if (baud_tick && !sync_m) begin
                  rx_cnt_ff <= (rx_cnt_ff == spb_m1) ? 4'h0 : rx_cnt_ff + 4'h1;
               end
               if (rx_tick) begin
                  rx_idx_ff <= rx_idx_ff + 4'h1;
                  if (rx_idx_ff == 4'h0) begin
                     if (rx_bit) rx_state_ff <= RX_IDLE;
                  end else if (rx_idx_ff <= nbits) begin
                     rx_sh_ff  <= {rx_bit, rx_sh_ff[8:1]};
                     rx_par_ff <= rx_par_ff ^ rx_bit;
                  end else if (par_en && (rx_idx_ff == nbits + 4'h1)) begin
                     rx_pe_ff <= rx_par_ff ^ rx_bit ^ par_odd;
                  end else begin
                     // Only the first stop bit is checked
                     rx_fe_ff    <= !rx_bit;
                     rx_state_ff <= RX_HOLD;
                  end
               end
            end
            RX_HOLD: begin
               // Character waits here while the FIFO is full
               if (start_seen) begin
                  rx_state_ff <= RX_BUSY;
                  rx_cnt_ff   <= '0;
                  rx_idx_ff   <= sync_m ? 4'h1 : 4'h0;
                  rx_par_ff   <= 1'b0;
                  rx_pe_ff    <= 1'b0;
                  if (!fifo_in_ready) ovr_pend_ff <= 1'b1;
               end else if (fifo_in_ready) begin
                  rx_state_ff <= RX_IDLE;
               end
            end
            default: rx_state_ff <= RX_IDLE;
         endcase
      end
   end

   usart_fifo #(
      .WIDTH (RX_WORD_W),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .flush_i     (!rx_run),
      .in_valid_i  (rx_state_ff == RX_HOLD),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({rx_pe_ff, rx_fe_ff, ovr_pend_ff, rx_aligned}),
      .out_valid_o (rx_complete_o),
      .out_ready_i (rx_pop_i),
      .out_data_o  (rx_head)
   );

   // Status comes with the head entry and goes with the pop
   assign serial_data_location_o = rx_head[7:0];
   assign rx_ninth_bit_o         = rx_head[8];
   assign overrun_flag_o         = rx_head[RX_OVR_POS];
   assign frame_error_flag_o     = rx_head[RX_FE_POS];
   assign parity_error_o         = rx_head[RX_PE_POS];

endmodule : usart_core

// File: hw/usart_pkg.sv
// Constants and types of the serial unit
package usart_pkg;

   localparam int          CLK_PERIOD_NS     = 50;
   localparam int          DIV_W             = 12;
   localparam logic [11:0] DIVISOR_RST       = 12'h000;
   localparam logic [4:0]  SPB_NORMAL        = 5'h10;
   localparam logic [4:0]  SPB_DOUBLE        = 5'h08;
   localparam int          RX_FIFO_DEPTH_DEF = 2;
   localparam int          FRAME_W           = 13;
   localparam int          DATA_W            = 9;
   localparam int          RX_WORD_W         = 12;
   localparam int          RX_OVR_POS        = 9;
   localparam int          RX_FE_POS         = 10;
   localparam int          RX_PE_POS         = 11;
   localparam logic [2:0]  CS_5              = 3'h0;
   localparam logic [2:0]  CS_6              = 3'h1;
   localparam logic [2:0]  CS_7              = 3'h2;
   localparam logic [2:0]  CS_8              = 3'h3;
   localparam logic [2:0]  CS_9              = 3'h7;
   localparam logic [1:0]  PAR_EVEN          = 2'h2;
   localparam logic [1:0]  PAR_ODD           = 2'h3;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_BUSY = 2'b01,
      RX_HOLD = 2'b10
   } rx_state_t;

   typedef enum logic {
      TX_IDLE  = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;

   // Size code to data bits; unused codes give 8
   function automatic logic [3:0] data_bits(input logic [2:0] cs);
      unique case (cs)
         CS_5:    data_bits = 4'h5;
         CS_6:    data_bits = 4'h6;
         CS_7:    data_bits = 4'h7;
         CS_9:    data_bits = 4'h9;
         default: data_bits = 4'h8;
      endcase
   endfunction : data_bits

endpackage : usart_pkg

// File: hw/usart_fifo.sv
// Receive FIFO, valid/ready on both sides
`timescale 1ns/1ns
module usart_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : next_ptr

   assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_ff != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_ff[rd_ff];

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else if (flush_i) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= next_ptr(wr_ff);
         if (pop) rd_ff <= next_ptr(rd_ff);
         if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
         else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < DEPTH; i++) mem_ff[i] <= '0;
      end else if (push) begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

endmodule : usart_fifo

// File: hw/usart_baud_gen.sv
// Baud down-counter: one tick per zero count
`timescale 1ns/1ns
module usart_baud_gen import usart_pkg::*; #(
   parameter int W = DIV_W
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] divisor_i,
   input  wire logic         reload_i,
   output logic              tick_o
);
   logic [W-1:0] cnt_ff;
   logic         tick_ff;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_ff <= W'(DIVISOR_RST);
      end else if (!run_i || reload_i || cnt_ff == '0) begin
         cnt_ff <= divisor_i;
      end else begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   // Registered: a clean one-cycle enable
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) tick_ff <= 1'b0;
      else tick_ff <= run_i && !reload_i && (cnt_ff == '0);
   end

   assign tick_o = tick_ff;

endmodule : usart_baud_gen

// File: tb/usart_assertions.sv
// Checks on the serial unit core ports
`timescale 1ns/1ns
module usart_assertions import usart_pkg::*; #(
   parameter int RX_DEPTH = RX_FIFO_DEPTH_DEF
) (
   input logic       clk_i,
   input logic       sys_rst_i,
   input logic       serial_power_reduce_bit_i,
   input logic       tx_enable_i,
   input logic       rx_enable_i,
   input logic       sync_mode_select_i,
   input logic       transfer_clock_direction_i,
   input logic       tx_valid_i,
   input logic       tx_ready_o,
   input logic       tx_empty_o,
   input logic       tx_complete_o,
   input logic       rx_complete_o,
   input logic       rx_pop_i,
   input logic [7:0] serial_data_location_o,
   input logic       frame_error_flag_o,
   input logic       overrun_flag_o,
   input logic       txd_o,
   input logic       txd_oe_o,
   input logic       transfer_clock_pin_o,
   input logic       transfer_clock_pin_oe_o
);
   logic run, mst;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   assign run = !serial_power_reduce_bit_i;
   assign mst = sync_mode_select_i && transfer_clock_direction_i;
   // Idle, finished shifter loads at once
   sequence s_idle_take;
      tx_valid_i && tx_ready_o && tx_complete_o && !sync_mode_select_i;
   endsequence
   sequence s_load_start;
      !tx_ready_o ##1 tx_ready_o ##[0:1] !txd_o;
   endsequence
   a_ready_rule: assert property (tx_ready_o == (tx_enable_i && run && tx_empty_o))
      else $error("ready wrong");
   a_take_fills: assert property (tx_valid_i && tx_ready_o |=> !tx_empty_o && !tx_ready_o)
      else $error("buffer not filled");
   a_idle_start: assert property (s_idle_take |=> s_load_start)
      else $error("frame not started");
   a_txd_drive: assert property (txd_oe_o == (run && tx_enable_i))
      else $error("txd enable wrong");
   a_pin_drive: assert property (transfer_clock_pin_oe_o == (run && mst))
      else $error("clock pin enable wrong");
   a_pin_quiet: assert property (!mst |=> !transfer_clock_pin_o)
      else $error("pin not quiet");
   a_rx_flush: assert property (!rx_enable_i |=> !rx_complete_o)
      else $error("buffer not flushed");
   a_head_stands: assert property (rx_complete_o && !rx_pop_i && rx_enable_i && run |=>
      rx_complete_o && $stable(serial_data_location_o) && $stable(frame_error_flag_o)
      && $stable(overrun_flag_o)) else $error("head moved");
endmodule : usart_assertions
bind usart_core usart_assertions #(.RX_DEPTH(RX_DEPTH)) usart_assertions_inst (.*);

// File: tb/usart_line_model.sv
// Far-side partner: drives rxd, decodes txd
`timescale 1ns/1ns
module usart_line_model (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   initial rxd_o = 1'b1;
   task automatic bit_out(input logic v, input int b);
      rxd_o = v;
      repeat (b) @(negedge clk_i);
   endtask : bit_out
   task automatic send(input logic [8:0] d, input int n, b, input logic [1:0] p,
                       input logic bad_par, stop);
      logic par;
      par = p[0] ^ bad_par;
      @(negedge clk_i);
      bit_out(1'b0, b);
      for (int i = 0; i < n; i++) begin
         par ^= d[i];
         bit_out(d[i], b);
      end
      if (p[1]) bit_out(par, b);
      // A short low stop leaves a false start
      bit_out(stop, stop ? b : 3 * b / 4);
      bit_out(1'b1, 2 * b);
   endtask : send
   task automatic recv(output logic [8:0] d, output logic par, ok, output int w,
                       input int n, b, input logic [1:0] p);
      d = '0;
      par = 1'b0;
      w = 0;
      while (txd_i && w < 9000) begin
         @(negedge clk_i);
         w++;
      end
      repeat (b / 2) @(negedge clk_i);
      ok = !txd_i;
      for (int i = 0; i < n; i++) begin
         repeat (b) @(negedge clk_i);
         d[i] = txd_i;
      end
      if (p[1]) begin
         repeat (b) @(negedge clk_i);
         par = txd_i;
      end
      repeat (b) @(negedge clk_i);
      ok = ok & txd_i;
   endtask : recv
endmodule : usart_line_model

// File: tb/tb.sv
// Self-checking bench for the serial unit core
`timescale 1ns/1ns
module tb import usart_pkg::*;;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, serial_power_reduce_bit_i = 1'b0, rxd_i;
   logic tx_enable_i = 1'b1, rx_enable_i = 1'b1, sync_mode_select_i = 1'b0;
   logic double_speed_bit_i = 1'b0, transfer_clock_direction_i = 1'b0, two_stop_i = 1'b0;
   logic sync_clock_polarity_i = 1'b0, baud_divisor_low_wr_i = 1'b0, tx_valid_i = 1'b0;
   logic tx_complete_clr_i = 1'b0, rx_pop_i = 1'b0, transfer_clock_pin_i = 1'b0;
   logic [2:0] char_size_i = CS_8;
   logic [1:0] parity_mode_i = PAR_ODD;
   logic [7:0] baud_divisor_low_i = 8'h01, serial_data_location_o;
   logic [3:0] baud_divisor_high_i = 4'h0;
   logic [8:0] tx_data_i = 9'h000;
   logic tx_ready_o, tx_empty_o, tx_complete_o, rx_ninth_bit_o, frame_error_flag_o, txd_o;
   logic overrun_flag_o, parity_error_o, rx_complete_o, txd_oe_o;
   logic transfer_clock_pin_o, transfer_clock_pin_oe_o;
   int   bad_count = 0, n_checks = 0;
   always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
   usart_core usart_core_inst (.*);
   usart_line_model usart_line_model_inst (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic tx_write(input logic [8:0] d);
      int w = 0;
      @(negedge clk_i);
      tx_data_i = d;
      tx_valid_i = 1'b1;
      while (!tx_ready_o && w < 9000) begin
         @(negedge clk_i);
         w++;
      end
      chk("tx take", 9'h001, tx_ready_o);
      if (!tx_ready_o) give_verdict();
      @(negedge clk_i);
      tx_valid_i = 1'b0;
   endtask : tx_write
   task automatic head(input logic [8:0] d, input logic fe, pe, ov);
      int w = 0;
      while (!rx_complete_o && w < 9000) begin
         @(negedge clk_i);
         w++;
      end
      chk("rx avail", 9'h001, rx_complete_o);
      if (!rx_complete_o) give_verdict();
      chk("rx data", d, {(char_size_i == CS_9) & rx_ninth_bit_o, serial_data_location_o});
      chk("frame error", fe, frame_error_flag_o);
      chk("parity error", pe, parity_error_o);
      chk("overrun", ov, overrun_flag_o);
      rx_pop_i = 1'b1;
      @(negedge clk_i);
      rx_pop_i = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask : head
   task automatic check_reset();
      chk("txd idle", 9'h001, txd_o);
      chk("flags", 9'h008, {tx_empty_o, tx_complete_o, rx_complete_o, overrun_flag_o});
      serial_power_reduce_bit_i = 1'b1;
      rx_enable_i = 1'b0;
      @(negedge clk_i);
      chk("power off", 9'h000, {tx_ready_o, txd_oe_o});
      serial_power_reduce_bit_i = 1'b0;
      rx_enable_i = 1'b1;
      $display("reset done");
   endtask : check_reset
   task automatic test_tx_sizes();
      logic [2:0] cs [5] = '{CS_5, CS_6, CS_7, CS_8, CS_9};
      logic [8:0] d [2], m;
      logic       p [2], ok [2];
      int         w [2];
      for (int i = 0; i < 5; i++) begin
         char_size_i = cs[i];
         m = 9'h1ff >> (4 - i);
         @(negedge clk_i);
         tx_complete_clr_i = 1'b1;
         @(negedge clk_i);
         tx_complete_clr_i = 1'b0;
         fork
            begin
               tx_write(9'h1a5);
               tx_write(9'h05a);
            end
            begin
               usart_line_model_inst.recv(d[0], p[0], ok[0], w[0], i + 5, 32, PAR_ODD);
               usart_line_model_inst.recv(d[1], p[1], ok[1], w[1], i + 5, 32, PAR_ODD);
            end
         join
         chk("tx data", 9'h1a5 & m, d[0]);
         chk("tx data", 9'h05a & m, d[1]);
         chk("tx parity", {~^(9'h1a5 & m), ~^(9'h05a & m)}, {p[0], p[1]});
         chk("tx gap", 9'h001, w[1] <= 18);
         chk("tx stop", 9'h001, ok[0] & ok[1]);
         repeat (32) @(negedge clk_i);
         chk("tx done", 9'h001, tx_complete_o);
      end
      $display("tx sizes done");
   endtask : test_tx_sizes
   task automatic test_double();
      logic [8:0] d;
      logic       p, ok;
      int         w;
      parity_mode_i = PAR_EVEN;
      char_size_i = CS_8;
      double_speed_bit_i = 1'b1;
      fork
         usart_line_model_inst.send(9'h0c3, 8, 16, PAR_EVEN, 1'b0, 1'b1);
         tx_write(9'h03c);
         usart_line_model_inst.recv(d, p, ok, w, 8, 16, PAR_EVEN);
      join
      chk("tx data", 9'h13c, {ok, d[7:0]});
      chk("tx parity", 9'h000, p);
      head(9'h0c3, 1'b0, 1'b0, 1'b0);
      double_speed_bit_i = 1'b0;
      $display("double speed done");
   endtask : test_double
   task automatic test_rx();
      usart_line_model_inst.send(9'h011, 8, 32, PAR_EVEN, 1'b0, 1'b0);
      usart_line_model_inst.send(9'h022, 8, 32, PAR_EVEN, 1'b1, 1'b1);
      usart_line_model_inst.send(9'h033, 8, 32, PAR_EVEN, 1'b0, 1'b1);
      head(9'h011, 1'b1, 1'b0, 1'b0);
      head(9'h022, 1'b0, 1'b1, 1'b0);
      head(9'h033, 1'b0, 1'b0, 1'b0);
      chk("rx empty", 9'h000, rx_complete_o);
      $display("rx buffer done");
   endtask : test_rx
   task automatic test_overrun();
      logic [8:0] v [4] = '{9'h1a5, 9'h0f0, 9'h13c, 9'h055};
      char_size_i = CS_9;
      foreach (v[k]) usart_line_model_inst.send(v[k], 9, 32, PAR_EVEN, 1'b0, 1'b1);
      head(v[0], 1'b0, 1'b0, 1'b0);
      head(v[1], 1'b0, 1'b0, 1'b0);
      head(v[3], 1'b0, 1'b0, 1'b1);
      $display("overrun done");
   endtask : test_overrun
   task automatic test_master();
      int   c;
      logic q;
      sync_mode_select_i = 1'b1;
      transfer_clock_direction_i = 1'b1;
      for (int dv = 1; dv <= 4; dv *= 2) begin
         baud_divisor_low_i = dv[7:0];
         baud_divisor_low_wr_i = 1'b1;
         @(negedge clk_i);
         baud_divisor_low_wr_i = 1'b0;
         repeat (8) @(negedge clk_i);
         c = 0;
         q = transfer_clock_pin_o;
         repeat (20 * (dv + 1)) begin
            @(negedge clk_i);
            c += int'(transfer_clock_pin_o !== q);
            q = transfer_clock_pin_o;
         end
         chk("pin toggles", 9'h014, c[8:0]);
      end
      $display("master clock done");
   endtask : test_master
   initial begin
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      check_reset();
      test_tx_sizes();
      test_double();
      test_rx();
      test_overrun();
      test_master();
      give_verdict();
   end
endmodule : tb
